// [design/dcrp_pkg.sv]
package dcrp_pkg;
    localparam int MEM_DQ_W   = 16;
    localparam int MEMORY_DATA_MASK_W   = MEM_DQ_W / 8;
    localparam int LOC_DATA_W = 2 * MEM_DQ_W;
    localparam int LOC_BE_W   = LOC_DATA_W / 8;
    localparam int CHIP_W     = 4;
    localparam int ROW_W      = 13;
    localparam int BANK_W     = 2;
    localparam int COL_W      = 10;
    localparam int COL_DROP   = 1;
    localparam int ADDR_W     = ROW_W + BANK_W + COL_W - COL_DROP;
    localparam int MAX_BURST  = 64;
    localparam int SIZE_W     = 7;
    localparam int MEM_BA_W   = BANK_W;

    typedef enum logic [1:0]
    {
        DCRP_CMD_NONE  = 2'b00,
        DCRP_CMD_READ  = 2'b01,
        DCRP_CMD_WRITE = 2'b10,
        DCRP_CMD_RFSH  = 2'b11
    } dcrp_cmd_t;
endpackage : dcrp_pkg

// [design/dcrp_if.sv]
`timescale 1ns/10ps
interface dcrp_if;
    import dcrp_pkg::*;
    logic                  localReady;
    logic                  readReq;
    logic                  writeReq;
    logic                  burstBegin;
    logic [ADDR_W-1:0]     address;
    logic [SIZE_W-1:0]     size;
    logic [LOC_DATA_W-1:0] wdata;
    logic [LOC_BE_W-1:0]   write_byte_mask;
    logic                  refreshReq;
    logic [CHIP_W-1:0]     refreshChip;

    modport ctrl
    (
        output localReady,
        input  readReq, writeReq, burstBegin, address, size, wdata,
        input  write_byte_mask, refreshReq, refreshChip
    );
    modport master
    (
        input  localReady,
        output readReq, writeReq, burstBegin, address, size, wdata,
        output write_byte_mask, refreshReq, refreshChip
    );
endinterface : dcrp_if

// [design/dcrp_beat_split.sv]
`timescale 1ns/10ps
module dcrp_beat_split
    import dcrp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  load,
    input  wire logic [LOC_DATA_W-1:0] word,
    input  wire logic [LOC_BE_W-1:0]   byteMask,
    output logic                       beatValid,
    output logic [MEM_DQ_W-1:0]        memDq,
    output logic [MEMORY_DATA_MASK_W-1:0]        memory_data_mask
);
    import dcrp_pkg::*;

    logic [MEM_DQ_W-1:0] upperData_ff, nxt_upperData;
    logic [MEMORY_DATA_MASK_W-1:0] upperMask_ff, nxt_upperMask;
    logic                upperPend_ff, nxt_upperPend;
    logic [MEM_DQ_W-1:0] dq_ff, nxt_dq;
    logic [MEMORY_DATA_MASK_W-1:0] dm_ff, nxt_dm;
    logic                valid_ff, nxt_valid;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_upperData = upperData_ff;
        nxt_upperMask = upperMask_ff;
        nxt_upperPend = 1'b0;
        nxt_dq        = dq_ff;
        nxt_dm        = {MEMORY_DATA_MASK_W{1'b1}};
        nxt_valid     = 1'b0;
        if (upperPend_ff)
        begin
            nxt_dq    = upperData_ff;                     // see RL3
            nxt_dm    = upperMask_ff;
            nxt_valid = 1'b1;
        end
        if (load)
        begin
            // lower half first, upper half next beat
            nxt_dq        = word[MEM_DQ_W-1:0];             // see RL3
            nxt_dm        = ~byteMask[MEMORY_DATA_MASK_W-1:0];        // see RL1 see RL2
            nxt_upperData = word[LOC_DATA_W-1:MEM_DQ_W];
            nxt_upperMask = ~byteMask[LOC_BE_W-1:MEMORY_DATA_MASK_W]; // see RL2
            nxt_upperPend = 1'b1;
            nxt_valid     = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            upperData_ff <= '0;
            upperMask_ff <= '1;
            upperPend_ff <= 1'b0;
            dq_ff        <= '0;
            dm_ff        <= '1;
            valid_ff     <= 1'b0;
        end
        else
        begin
            upperData_ff <= nxt_upperData;
            upperMask_ff <= nxt_upperMask;
            upperPend_ff <= nxt_upperPend;
            dq_ff        <= nxt_dq;
            dm_ff        <= nxt_dm;
            valid_ff     <= nxt_valid;
        end
    end

    assign memDq            = dq_ff;
    assign memory_data_mask = dm_ff;
    assign beatValid        = valid_ff;
endmodule : dcrp_beat_split

// [design/dcrp_ctrl_end.sv]
`timescale 1ns/10ps
// Behaviour
// RL1: masked-off byte lanes are not written
// RL2: byte mask high, memory mask low
// RL3: lower half first, then upper half
// RL4: burst start is one pulse only
// RL5: master pulses burst start per write burst; the master sends none when userSize is zero
// RL6: burst start sampled with write request
// RL7: master holds write request while not ready
// RL8: read burst start pulses with read address; the master sends none when userSize is zero
// RL9: master holds read request while not ready
// RL10: never read and write together
// RL11: user refresh input; master meets refresh needs
// RL12: back-to-back refreshes allowed
// RL13: refresh beats pending reads and writes
// RL14: refresh chip mask high, qualified, chip-wide
// RL15: refresh exactly the masked chips
// RL16: beat count unsigned, one to sixty-four
// RL17: master keeps beat count within maximum; the master passes counts above 64 unchanged and the controller clamps them
// RL18: local word twice memory width
// RL19: drop lowest column bit
// RL20: half-rate drops two column bits
// RL21: accept only while ready is high
// RL22: accept write beats until count done
module dcrp_ctrl_end
    import dcrp_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    dcrp_if.ctrl               loc,
    input  wire logic          cmdReady,
    output logic [1:0]         cmdKind,
    output logic               cmdValid,
    output logic [ROW_W-1:0]   cmdRow,
    output logic [MEM_BA_W-1:0] cmdBank,
    output logic [COL_W-1:0]   cmdCol,
    output logic [SIZE_W-1:0]  cmdBeats,
    output logic [CHIP_W-1:0]  cmdChips,
    output logic               memBeatValid,
    output logic [MEM_DQ_W-1:0] memDq,
    output logic [MEMORY_DATA_MASK_W-1:0] memory_data_mask
);
    import dcrp_pkg::*;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_WDATA = 2'b01,
        ST_ISSUE = 2'b10
    } dcrp_state_t;

    dcrp_state_t           state_ff, nxt_state;
    dcrp_cmd_t             kind_ff, nxt_kind;
    logic                  valid_ff, nxt_valid;
    logic [ROW_W-1:0]      row_ff, nxt_row;
    logic [MEM_BA_W-1:0]   bank_ff, nxt_bank;
    logic [COL_W-1:0]      col_ff, nxt_col;
    logic [SIZE_W-1:0]     beats_ff, nxt_beats;
    logic [CHIP_W-1:0]     chips_ff, nxt_chips;
    logic [SIZE_W-1:0]     left_ff, nxt_left;
    logic                  ready;
    logic                  loadBeat;
    logic                  bbHeld_ff, nxt_bbHeld;
    logic                  halfPend_ff, nxt_halfPend;
    logic                  startBurst;

    // clamp illegal counts; zero counts as one beat
    function automatic logic [SIZE_W-1:0] clampSize(input logic [SIZE_W-1:0] s);
        if (s == '0)
            clampSize = SIZE_W'(1);
        else if (s > SIZE_W'(MAX_BURST))
            clampSize = SIZE_W'(MAX_BURST);
        else
            clampSize = s;
    endfunction : clampSize

    ////////////////////////////////////////////////////////////////////////
    // ready drops while a command waits downstream; combinational handshake
    // a word in flight still owes its upper beat; only writes continue a burst
    always_comb
    begin
        ready = (state_ff == ST_IDLE) ||
                ((state_ff == ST_WDATA) && !halfPend_ff && !loc.readReq && !loc.refreshReq);
    end

    assign loc.localReady = ready;
    // burst start may arrive while ready is low; kept until the request is taken, except one that arrives in ST_WDATA, which is not held
    assign startBurst = loc.burstBegin || bbHeld_ff;                 // see RL6
    assign loadBeat = ready && loc.writeReq && ((state_ff == ST_WDATA) ||
                      ((state_ff == ST_IDLE) && startBurst && !loc.refreshReq));

    always_comb
    begin
        nxt_state = state_ff;
        nxt_kind  = kind_ff;
        nxt_valid = valid_ff;
        nxt_row   = row_ff;
        nxt_bank  = bank_ff;
        nxt_col   = col_ff;
        nxt_beats = beats_ff;
        nxt_chips = chips_ff;
        nxt_left  = left_ff;
        nxt_halfPend = loadBeat;
        nxt_bbHeld   = bbHeld_ff || (loc.burstBegin && (loc.readReq || loc.writeReq) &&
                       (state_ff != ST_WDATA));
        case (state_ff)
            ST_IDLE:
            begin
                // refresh first; it only beats requests not yet started
                if (loc.refreshReq)                                  // see RL13 see RL21
                begin
                    nxt_kind  = DCRP_CMD_RFSH;
                    nxt_chips = loc.refreshChip;                     // see RL14 see RL15
                    nxt_valid = 1'b1;
                    nxt_state = ST_ISSUE;                            // see RL12 see RL11
                end
                else if ((loc.writeReq || loc.readReq) && startBurst) // see RL6
                begin
                    nxt_bbHeld = 1'b0;
                    nxt_kind  = loc.writeReq ? DCRP_CMD_WRITE : DCRP_CMD_READ;
                    nxt_row   = loc.address[ADDR_W-1 -: ROW_W];
                    nxt_bank  = loc.address[COL_W-COL_DROP +: BANK_W];
                    // COL_DROP low column bits implied by the wide word; see RL20
                    nxt_col   = {loc.address[COL_W-COL_DROP-1:0], {COL_DROP{1'b0}}}; // see RL19
                    nxt_beats = clampSize(loc.size);                 // see RL16
                    nxt_chips = '0;
                    if (loc.writeReq && clampSize(loc.size) != SIZE_W'(1))
                    begin
                        nxt_left  = SIZE_W'(clampSize(loc.size) - SIZE_W'(1)); // see RL22
                        nxt_state = ST_WDATA;
                    end
                    else
                    begin
                        nxt_valid = 1'b1;
                        nxt_state = ST_ISSUE;
                    end
                end
            end
            ST_WDATA:
            begin
                if (loadBeat)                                        // see RL22
                begin
                    nxt_left = SIZE_W'(left_ff - SIZE_W'(1));
                    if (left_ff == SIZE_W'(1))
                    begin
                        nxt_valid = 1'b1;
                        nxt_state = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE:
            begin
                if (cmdReady)
                begin
                    nxt_valid = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_IDLE;
            kind_ff  <= DCRP_CMD_NONE;
            valid_ff <= 1'b0;
            row_ff   <= '0;
            bank_ff  <= '0;
            col_ff   <= '0;
            beats_ff <= '0;
            chips_ff <= '0;
            left_ff  <= '0;
            bbHeld_ff   <= 1'b0;
            halfPend_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            kind_ff  <= nxt_kind;
            valid_ff <= nxt_valid;
            row_ff   <= nxt_row;
            bank_ff  <= nxt_bank;
            col_ff   <= nxt_col;
            beats_ff <= nxt_beats;
            chips_ff <= nxt_chips;
            left_ff  <= nxt_left;
            bbHeld_ff   <= nxt_bbHeld;
            halfPend_ff <= nxt_halfPend;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    dcrp_beat_split u_split
    (
        .clk              (clk),
        .rst_b            (rst_b),
        .load             (loadBeat),            // see RL18 see RL21
        .word             (loc.wdata),
        .byteMask         (loc.write_byte_mask),
        .beatValid        (memBeatValid),
        .memDq            (memDq),
        .memory_data_mask (memory_data_mask)     // see RL1 see RL3
    );

    assign cmdKind  = kind_ff;
    assign cmdValid = valid_ff;
    assign cmdRow   = row_ff;
    assign cmdBank  = bank_ff;
    assign cmdCol   = col_ff;
    assign cmdBeats = beats_ff;
    assign cmdChips = chips_ff;
endmodule : dcrp_ctrl_end

// [design/dcrp_master_end.sv]
`timescale 1ns/10ps
module dcrp_master_end
    import dcrp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    dcrp_if.master                     loc,
    input  wire logic                  userValid,
    input  wire logic                  userWrite,
    input  wire logic [ADDR_W-1:0]     userAddr,
    input  wire logic [SIZE_W-1:0]     userSize,
    input  wire logic [LOC_DATA_W-1:0] userData,
    input  wire logic [LOC_BE_W-1:0]   userMask,
    input  wire logic                  userRefresh,
    input  wire logic [CHIP_W-1:0]     userChips,
    output logic                       userReady
);
    import dcrp_pkg::*;

    logic                  rd_ff, nxt_rd;
    logic                  wr_ff, nxt_wr;
    logic                  bb_ff, nxt_bb;
    logic                  rf_ff, nxt_rf;
    logic [ADDR_W-1:0]     addr_ff, nxt_addr;
    logic [SIZE_W-1:0]     size_ff, nxt_size;
    logic [LOC_DATA_W-1:0] data_ff, nxt_data;
    logic [LOC_BE_W-1:0]   mask_ff, nxt_mask;
    logic [CHIP_W-1:0]     chip_ff, nxt_chip;
    logic                  busy;
    logic                  done;

    ////////////////////////////////////////////////////////////////////////
    // one user item per local beat; held until the controller is ready
    assign busy      = rd_ff || wr_ff || rf_ff;
    assign done      = loc.localReady;
    assign userReady = !busy || done;

    always_comb
    begin
        nxt_rd   = rd_ff;
        nxt_wr   = wr_ff;
        nxt_rf   = rf_ff;
        nxt_addr = addr_ff;
        nxt_size = size_ff;
        nxt_data = data_ff;
        nxt_mask = mask_ff;
        nxt_chip = chip_ff;
        nxt_bb   = 1'b0;                                   // see RL4 see RL5
        if (busy && done)
        begin
            nxt_rd = 1'b0;
            nxt_wr = 1'b0;
            nxt_rf = 1'b0;
        end
        if (userReady && userValid)
        begin
            // read and write never together
            nxt_rd   = !userRefresh && !userWrite;         // see RL10 see RL8
            nxt_wr   = !userRefresh && userWrite;
            nxt_rf   = userRefresh;                        // see RL11 see RL14
            nxt_chip = userChips;
            nxt_addr = userAddr;
            nxt_size = (userSize == '0) ? SIZE_W'(1) : userSize; // see RL17
            nxt_data = userData;
            nxt_mask = userMask;
            nxt_bb   = !userRefresh && (userSize != '0);   // see RL5 see RL8
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_ff   <= 1'b0;
            wr_ff   <= 1'b0;
            bb_ff   <= 1'b0;
            rf_ff   <= 1'b0;
            addr_ff <= '0;
            size_ff <= '0;
            data_ff <= '0;
            mask_ff <= '0;
            chip_ff <= '0;
        end
        else
        begin
            rd_ff   <= nxt_rd;                             // see RL7 see RL9
            wr_ff   <= nxt_wr;
            bb_ff   <= nxt_bb;
            rf_ff   <= nxt_rf;
            addr_ff <= nxt_addr;
            size_ff <= nxt_size;
            data_ff <= nxt_data;
            mask_ff <= nxt_mask;
            chip_ff <= nxt_chip;
        end
    end

    assign loc.readReq         = rd_ff;
    assign loc.writeReq        = wr_ff;
    assign loc.burstBegin      = bb_ff;
    assign loc.refreshReq      = rf_ff;
    assign loc.address         = addr_ff;
    assign loc.size            = size_ff;
    assign loc.wdata           = data_ff;
    assign loc.write_byte_mask = mask_ff;
    assign loc.refreshChip     = chip_ff;
endmodule : dcrp_master_end

// [bench/dcrp_assertions.sv]
`timescale 1ns/10ps
module dcrp_assertions
    import dcrp_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  localReady,
    input wire logic                  readReq,
    input wire logic                  writeReq,
    input wire logic                  burstBegin,
    input wire logic [ADDR_W-1:0]     address,
    input wire logic [SIZE_W-1:0]     size,
    input wire logic [LOC_DATA_W-1:0] wdata,
    input wire logic [LOC_BE_W-1:0]   write_byte_mask,
    input wire logic                  refreshReq,
    input wire logic [CHIP_W-1:0]     refreshChip,
    input wire logic                  cmdReady,
    input wire logic [1:0]            cmdKind,
    input wire logic                  cmdValid,
    input wire logic [COL_W-1:0]      cmdCol,
    input wire logic [SIZE_W-1:0]     cmdBeats,
    input wire logic [CHIP_W-1:0]     cmdChips,
    input wire logic                  memBeatValid,
    input wire logic [MEM_DQ_W-1:0]   memDq,
    input wire logic [MEMORY_DATA_MASK_W-1:0]   memory_data_mask
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    no_rd_wr_a: assert property (!(readReq && writeReq))
        else $error("read and write requested together");
    begin_pulse_a: assert property (burstBegin |=> !burstBegin)
        else $error("burst start held past one cycle");
    write_hold_a: assert property (writeReq && !localReady |=> writeReq && $stable(wdata)
        && $stable(write_byte_mask) && $stable(address))
        else $error("write request changed while not ready");
    read_hold_a: assert property (readReq && !localReady |=> readReq && $stable(address)
        && $stable(size))
        else $error("read request changed while not ready");
    size_range_a: assert property (burstBegin |-> size >= 7'h01 && size <= MAX_BURST)
        else $error("beat count out of range");
    // full rate: lowest column bit always zero
    read_cmd_a: assert property (localReady && readReq && burstBegin && !refreshReq
        |=> cmdValid && cmdKind == 2'h1 && cmdBeats == $past(size)
        && cmdCol == {$past(address[COL_W-2:0]), 1'b0})
        else $error("read command wrong");
    refresh_cmd_a: assert property (localReady && refreshReq |=> cmdValid
        && cmdKind == 2'h3 && cmdChips == $past(refreshChip))
        else $error("refresh command wrong");
    write_beats_a: assert property (localReady && writeReq && burstBegin && size == 7'h01
        && !refreshReq |=> memBeatValid && memDq == $past(wdata[15:0])
        && memory_data_mask == ~$past(write_byte_mask[1:0]) ##1 memBeatValid
        && memDq == $past(wdata[31:16], 2) && memory_data_mask == ~$past(write_byte_mask[3:2], 2))
        else $error("write beats wrong");
    stall_ready_a: assert property (cmdValid && !cmdReady |-> !localReady)
        else $error("ready high while command stalled");
endmodule : dcrp_assertions

// [bench/ddr_ctrl_local_request_port_tb_top.sv]
`timescale 1ns/10ps
module ddr_ctrl_local_request_port_tb_top;
    import dcrp_pkg::*;
    logic                  clk, rst_b, cmdReady, cmdValid, memBeatValid;
    logic                  userValid, userWrite, userRefresh, userReady;
    logic [ADDR_W-1:0]     userAddr;
    logic [SIZE_W-1:0]     userSize, cmdBeats;
    logic [LOC_DATA_W-1:0] userData;
    logic [3:0]            userMask, userChips, cmdChips;
    logic [1:0]            cmdKind, cmdBank, memory_data_mask;
    logic [ROW_W-1:0]      cmdRow;
    logic [COL_W-1:0]      cmdCol;
    logic [MEM_DQ_W-1:0]   memDq;
    logic [63:0]           got;
    logic [63:0]           expCmd[$];
    logic [17:0]           expBeat[$];
    int                    n_mismatch, samples_checked;
    // window example words and the beats they must become
    logic [31:0]           wd[3] = '{32'h22334455, 32'h667788AA, 32'hBBCCDDEE};
    logic [3:0]            wm[3] = '{4'hC, 4'h6, 4'hA};
    logic [17:0]           wb[6] = '{{16'h4455, 2'h3}, {16'h2233, 2'h0}, {16'h88AA, 2'h1},
                                     {16'h6677, 2'h2}, {16'hDDEE, 2'h1}, {16'hBBCC, 2'h1}};
    ////////////////////////////////////////
    dcrp_if loc();
    dcrp_master_end i_dcrp_master_end (.clk(clk), .rst_b(rst_b), .loc(loc),
        .userValid(userValid), .userWrite(userWrite), .userAddr(userAddr), .userSize(userSize),
        .userData(userData), .userMask(userMask), .userRefresh(userRefresh),
        .userChips(userChips), .userReady(userReady));
    dcrp_ctrl_end i_dcrp_ctrl_end (.clk(clk), .rst_b(rst_b), .loc(loc), .cmdReady(cmdReady),
        .cmdKind(cmdKind), .cmdValid(cmdValid), .cmdRow(cmdRow), .cmdBank(cmdBank),
        .cmdCol(cmdCol), .cmdBeats(cmdBeats), .cmdChips(cmdChips), .memBeatValid(memBeatValid),
        .memDq(memDq), .memory_data_mask(memory_data_mask));
    dcrp_assertions i_dcrp_assertions (.clk(clk), .rst_b(rst_b), .localReady(loc.localReady),
        .readReq(loc.readReq), .writeReq(loc.writeReq), .burstBegin(loc.burstBegin),
        .address(loc.address), .size(loc.size), .wdata(loc.wdata),
        .write_byte_mask(loc.write_byte_mask), .refreshReq(loc.refreshReq),
        .refreshChip(loc.refreshChip), .cmdReady(cmdReady), .cmdKind(cmdKind),
        .cmdValid(cmdValid), .cmdCol(cmdCol), .cmdBeats(cmdBeats), .cmdChips(cmdChips),
        .memBeatValid(memBeatValid), .memDq(memDq), .memory_data_mask(memory_data_mask));
    ////////////////////////////////////////
    task check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // refresh commands carry only kind and chips; others carry the address split
    function logic [63:0] pk(input logic [1:0] k, input logic [23:0] a, input logic [6:0] s,
                             input logic [3:0] c);
        pk = (k == 2'h3) ? {58'h0, k, c} : {30'h0, k, a[23:11], a[10:9], a[8:0], 1'b0, s};
    endfunction : pk

    task send(input logic [1:0] k, input logic [23:0] a, input logic [6:0] s,
              input logic [31:0] d, input logic [3:0] m);
        int n;
        n = 0;
        expCmd.push_back(pk(k, a, s, m));
        userValid   <= 1'b1;
        userWrite   <= (k == 2'h2);
        userRefresh <= (k == 2'h3);
        userAddr    <= a;
        userSize    <= s;
        userData    <= d;
        userMask    <= m;
        userChips   <= m;
        @(posedge clk);
        while (userReady !== 1'b1 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        userValid   <= 1'b0;
        userRefresh <= 1'b0;
        check(n < 500, 1, "user port stuck");
        // one idle edge so the next call never re-drives userValid in this step
        @(posedge clk);
    endtask : send

    task settle(input string name);
        int n;
        n = 0;
        while ((expCmd.size() + expBeat.size()) != 0 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        check(expCmd.size() + expBeat.size(), 0, "missing output");
        $display("test %s done", name);
    endtask : settle
    ////////////////////////////////////////
    always @(posedge clk)
    begin
        if (rst_b === 1'b1 && cmdValid === 1'b1 && cmdReady === 1'b1)
        begin
            got = (cmdKind == 2'h3) ? {58'h0, cmdKind, cmdChips}
                : {30'h0, cmdKind, cmdRow, cmdBank, cmdCol, cmdBeats};
            check(got, expCmd.size() ? expCmd.pop_front() : '1, "command");
        end
        if (rst_b === 1'b1 && memBeatValid === 1'b1)
            check({memDq, memory_data_mask}, expBeat.size() ? expBeat.pop_front() : '1,
                  "memory beat");
    end

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // generous bound: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        {rst_b, userValid, userWrite, userRefresh, userAddr, userSize} = '0;
        {userData, userMask, userChips} = '0;
        cmdReady = 1'b1;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 3; i++)
        begin
            expBeat.push_back(wb[2*i]);
            expBeat.push_back(wb[2*i+1]);
            send(2'h2, 24'h000100 + 24'(i), 7'h01, wd[i], wm[i]);
        end
        settle("write lanes");
        send(2'h1, 24'hFFFFFF, 7'h01, 32'h0, 4'h0);
        send(2'h1, 24'h000001, SIZE_W'(MAX_BURST), 32'h0, 4'h0);
        send(2'h1, 24'hABC5FF, 7'h21, 32'h0, 4'h0);
        settle("read mapping");
        send(2'h3, 24'h0, 7'h01, 32'h0, 4'h5);
        send(2'h3, 24'h0, 7'h01, 32'h0, 4'hA);
        send(2'h3, 24'h0, 7'h01, 32'h0, 4'hF);
        settle("refresh group");
        cmdReady <= 1'b0;
        send(2'h1, 24'h123456, 7'h04, 32'h0, 4'h0);
        expBeat.push_back({16'h5678, 2'h2});
        expBeat.push_back({16'h1234, 2'h1});
        send(2'h2, 24'h000202, 7'h01, 32'h12345678, 4'h9);
        repeat (20) @(posedge clk);
        check(expCmd.size(), 2, "command issued while stalled");
        cmdReady <= 1'b1;
        settle("stall");
        wrap_up();
    end
endmodule : ddr_ctrl_local_request_port_tb_top
